// *** hdl/obt_pkg.sv ***
// Purpose: Shared constants and types of the on-off keying bit timer
// Assumes: 8-bit register port with a 3-bit word address
// Notes: Vector addresses are for the core's interrupt controller
package obt_pkg;

  // Register offsets (word index on the register port)
  localparam logic [2:0] OBT_OFS_COUNT = 3'h0;
  localparam logic [2:0] OBT_OFS_CTRL = 3'h1;
  localparam logic [2:0] OBT_OFS_STATUS = 3'h2;
  localparam logic [2:0] OBT_OFS_IRQ_EN = 3'h3;
  localparam logic [2:0] OBT_OFS_CLK_DIV = 3'h4;

  // Control register fields
  localparam int OBT_CTRL_HI_MSB = 7;
  localparam int OBT_CTRL_HI_LSB = 6;
  localparam int OBT_CTRL_MODE_MSB = 5;
  localparam int OBT_CTRL_MODE_LSB = 4;
  localparam int OBT_CTRL_PEND = 2;
  localparam int OBT_CTRL_RUN = 1;
  localparam int OBT_CTRL_DATA = 0;

  // Status and enable fields
  localparam int OBT_FLAG_EMPTY = 0;
  localparam int OBT_FLAG_DONE = 2;

  // Values after reset
  localparam logic [7:0] OBT_RST_COUNT = 8'h00;
  localparam logic [1:0] OBT_RST_COUNT_HI = 2'h0;
  localparam logic [7:0] OBT_RST_CLK_DIV = 8'h00;
  localparam logic [9:0] OBT_RST_CTR = 10'h000;
  localparam logic [7:0] OBT_RST_RDATA = 8'h00;

  // Interrupt vector addresses
  localparam logic [11:0] OBT_VEC_DONE = 12'h002;
  localparam logic [11:0] OBT_VEC_EMPTY = 12'h004;

  typedef enum logic [1:0] {
    OBT_OFF,
    OBT_TX,
    OBT_RX,
    OBT_GEN
  } obt_mode_t;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } obt_bus_req_t;

  // Whole state of the timer
  typedef struct packed {
    logic [7:0] cnt_lo;
    logic [1:0] cnt_hi;
    obt_mode_t mode;
    logic data;
    logic pend;
    logic run;
    logic [9:0] ctr;
    logic key;
    logic f_empty;
    logic f_done;
    logic en_empty;
    logic en_done;
    logic [7:0] div_ratio;
    logic [7:0] div_ctr;
    logic tick;
    logic [2:0] pin_sync;
    logic [7:0] rdata;
  } obt_state_t;

endpackage : obt_pkg

// *** hdl/obt_bit_timer.sv ***
// Purpose: Bit timer keying an on-off keyed transmitter, one bit per slot
// Assumes: Register port is synchronous to sys_clk_i, no wait states
// Notes: Slot base is a tick from a programmable divider of sys_clk_i
//
// Operation
// - Slot lasts base period times one plus 10-bit count value
// - Transmit mode keys the carrier on or off per data bit
// - Taking the pending bit sets flag 0, empty request if enabled
// - Count reaching zero with nothing pending sets flag 2, done request
// - Flags readable by polling without any interrupt enabled
// - Receive mode counts up, edge copies count into count register
// - Receive rising edge sets data bit, falling edge clears it
// - Generic mode never keys, raises request when count time elapses
// - Slot base is system clock from programmable divider
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps

module obt_bit_timer
  import obt_pkg::*;
#(
  parameter int CTR_W = 10
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire obt_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic capture_pin_i,
  output logic key_o,
  output logic irq_empty_o,
  output logic irq_done_o,
  output logic running_o
);

  obt_state_t s_q;
  obt_state_t s_d;

  // Full 10-bit count value from both registers
  function automatic logic [9:0] obt_countval(input obt_state_t st);
    obt_countval = {st.cnt_hi, st.cnt_lo};
  endfunction : obt_countval

  // Read mux for one register index
  function automatic logic [7:0] obt_read(input obt_state_t st,
                                          input logic [2:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      OBT_OFS_COUNT: begin
        v = st.cnt_lo;
      end
      OBT_OFS_CTRL: begin
        v[OBT_CTRL_HI_MSB:OBT_CTRL_HI_LSB] = st.cnt_hi;
        v[OBT_CTRL_MODE_MSB:OBT_CTRL_MODE_LSB] = st.mode;
        v[OBT_CTRL_PEND] = st.pend;
        v[OBT_CTRL_RUN] = st.run;
        v[OBT_CTRL_DATA] = st.data;
      end
      OBT_OFS_STATUS: begin
        v[OBT_FLAG_EMPTY] = st.f_empty;
        v[OBT_FLAG_DONE] = st.f_done;
      end
      OBT_OFS_IRQ_EN: begin
        v[OBT_FLAG_EMPTY] = st.en_empty;
        v[OBT_FLAG_DONE] = st.en_done;
      end
      OBT_OFS_CLK_DIV: begin
        v = st.div_ratio;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    obt_read = v;
  endfunction : obt_read

  logic wr_count;
  logic wr_ctrl;
  logic wr_status;
  logic wr_en;
  logic wr_div;
  logic set_empty;
  logic set_done;
  logic clr_empty;
  logic clr_done;
  logic pin_rise;
  logic pin_fall;
  logic take_bit;
  obt_mode_t wmode;

  // Next-state logic for the whole timer
  always_comb begin
    s_d = s_q;
    set_empty = 1'b0;
    set_done = 1'b0;
    take_bit = 1'b0;
    wr_count = bus_i.wr && (bus_i.addr == OBT_OFS_COUNT);
    wr_ctrl = bus_i.wr && (bus_i.addr == OBT_OFS_CTRL);
    wr_status = bus_i.wr && (bus_i.addr == OBT_OFS_STATUS);
    wr_en = bus_i.wr && (bus_i.addr == OBT_OFS_IRQ_EN);
    wr_div = bus_i.wr && (bus_i.addr == OBT_OFS_CLK_DIV);
    wmode = obt_mode_t'(bus_i.wdata[OBT_CTRL_MODE_MSB:OBT_CTRL_MODE_LSB]);
    clr_empty = wr_status && bus_i.wdata[OBT_FLAG_EMPTY];
    clr_done = wr_status && bus_i.wdata[OBT_FLAG_DONE];

    // Pin synchroniser; edges seen only on the settled stages
    s_d.pin_sync = {s_q.pin_sync[1:0], capture_pin_i};
    pin_rise = s_q.pin_sync[1] && !s_q.pin_sync[2];
    pin_fall = !s_q.pin_sync[1] && s_q.pin_sync[2];

    // Slot base tick from the programmable divider
    if (s_q.div_ctr == s_q.div_ratio) begin
      s_d.div_ctr = 8'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.div_ctr = s_q.div_ctr + 8'h01;
      s_d.tick = 1'b0;
    end

    // Mode engines
    case (s_q.mode)
      OBT_TX: begin
        if (!s_q.run) begin
          if (s_q.pend) begin
            take_bit = 1'b1;
          end
        end else if (s_q.tick) begin
          if (s_q.ctr == OBT_RST_CTR) begin
            if (s_q.pend) begin
              take_bit = 1'b1;
            end else begin
              s_d.run = 1'b0;
              s_d.key = 1'b0;
              set_done = 1'b1;
            end
          end else begin
            s_d.ctr = s_q.ctr - 10'h001;
          end
        end
        if (take_bit) begin
          s_d.ctr = obt_countval(s_q);
          s_d.key = s_q.data;
          s_d.pend = 1'b0;
          s_d.run = 1'b1;
          set_empty = 1'b1;
        end
      end
      OBT_RX: begin
        s_d.key = 1'b0;
        if (pin_rise || pin_fall) begin
          s_d.cnt_lo = s_q.ctr[7:0];
          s_d.cnt_hi = s_q.ctr[9:8];
          s_d.data = pin_rise;
          s_d.ctr = OBT_RST_CTR;
        end else if (s_q.tick && (s_q.ctr != {CTR_W{1'b1}})) begin
          s_d.ctr = s_q.ctr + 10'h001;
        end
      end
      OBT_GEN: begin
        s_d.key = 1'b0;
        if (s_q.run && s_q.tick) begin
          if (s_q.ctr == OBT_RST_CTR) begin
            s_d.run = 1'b0;
            set_done = 1'b1;
          end else begin
            s_d.ctr = s_q.ctr - 10'h001;
          end
        end
      end
      default: begin
        s_d.key = 1'b0;
        s_d.run = 1'b0;
      end
    endcase

    // Register writes
    if (wr_count) begin
      s_d.cnt_lo = bus_i.wdata;
    end
    if (wr_ctrl) begin
      s_d.cnt_hi = bus_i.wdata[OBT_CTRL_HI_MSB:OBT_CTRL_HI_LSB];
      s_d.mode = wmode;
      if (!(s_q.mode == OBT_RX && (pin_rise || pin_fall))) begin
        s_d.data = bus_i.wdata[OBT_CTRL_DATA];
      end
      if (wmode != s_q.mode) begin
        // Mode change restarts the engine from a clean state
        s_d.run = 1'b0;
        s_d.key = 1'b0;
        s_d.pend = 1'b0;
        s_d.ctr = OBT_RST_CTR;
        if (wmode == OBT_RX) begin
          s_d.run = 1'b1;
        end
        if (wmode == OBT_GEN) begin
          s_d.run = 1'b1;
          s_d.ctr = {bus_i.wdata[OBT_CTRL_HI_MSB:OBT_CTRL_HI_LSB],
                     s_d.cnt_lo};
        end
      end
      if (wmode == OBT_TX) begin
        s_d.pend = 1'b1;
      end
    end
    if (wr_en) begin
      s_d.en_empty = bus_i.wdata[OBT_FLAG_EMPTY];
      s_d.en_done = bus_i.wdata[OBT_FLAG_DONE];
    end
    if (wr_div) begin
      s_d.div_ratio = bus_i.wdata;
    end

    // Sticky flags; a hardware set wins over a clear
    s_d.f_empty = (s_q.f_empty && !clr_empty) || set_empty;
    s_d.f_done = (s_q.f_done && !clr_done) || set_done;

    // Read data stands only in the cycle after the strobe
    s_d.rdata = bus_i.rd ? obt_read(s_q, bus_i.addr) : OBT_RST_RDATA;
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q.cnt_lo <= OBT_RST_COUNT;
      s_q.cnt_hi <= OBT_RST_COUNT_HI;
      s_q.mode <= OBT_OFF;
      s_q.data <= 1'b0;
      s_q.pend <= 1'b0;
      s_q.run <= 1'b0;
      s_q.ctr <= OBT_RST_CTR;
      s_q.key <= 1'b0;
      s_q.f_empty <= 1'b0;
      s_q.f_done <= 1'b0;
      s_q.en_empty <= 1'b0;
      s_q.en_done <= 1'b0;
      s_q.div_ratio <= OBT_RST_CLK_DIV;
      s_q.div_ctr <= 8'h00;
      s_q.tick <= 1'b0;
      s_q.pin_sync <= 3'h0;
      s_q.rdata <= OBT_RST_RDATA;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign rdata_o = s_q.rdata;
  assign key_o = s_q.key;
  assign irq_empty_o = s_q.f_empty && s_q.en_empty;
  assign irq_done_o = s_q.f_done && s_q.en_done;
  assign running_o = s_q.run;

endmodule : obt_bit_timer

// *** tb/obt_bit_timer_props.sv ***
// Purpose: Port checker of the bit timer
// Assumes: Mode and enables follow register writes
// Notes: Bound to the timer at the foot
`timescale 1ns/100ps
module obt_bit_timer_props
  import obt_pkg::*;
#(
  parameter int CTR_W = 10
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire obt_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic capture_pin_i,
  input wire logic key_o,
  input wire logic irq_empty_o,
  input wire logic irq_done_o,
  input wire logic running_o
);
  logic [1:0] mode_q;
  logic [1:0] en_q;
  // Shadow of mode and enables
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= 2'h0;
      en_q <= 2'h0;
    end else if (bus_i.wr && bus_i.addr == OBT_OFS_CTRL) begin
      mode_q <= bus_i.wdata[5:4];
    end else if (bus_i.wr && bus_i.addr == OBT_OFS_IRQ_EN) begin
      en_q <= {bus_i.wdata[2], bus_i.wdata[0]};
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  property p_rd_zero;
    !$past(bus_i.rd) |-> rdata_o == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("read data outside read answer");
  property p_key_run;
    key_o |-> running_o;
  endproperty
  a_key_run: assert property (p_key_run)
    else $error("carrier keyed while idle");
  property p_no_key;
    mode_q != OBT_TX && $past(mode_q) != OBT_TX |-> !key_o;
  endproperty
  a_no_key: assert property (p_no_key)
    else $error("carrier keyed outside transmit");
  property p_irq_done;
    irq_done_o |-> en_q[1];
  endproperty
  a_irq_done: assert property (p_irq_done)
    else $error("done request while masked");
  property p_irq_empty;
    irq_empty_o |-> en_q[0];
  endproperty
  a_irq_empty: assert property (p_irq_empty)
    else $error("empty request while masked");
  property p_stat_done;
    bus_i.rd && bus_i.addr == OBT_OFS_STATUS && irq_done_o
      |=> rdata_o[OBT_FLAG_DONE];
  endproperty
  a_stat_done: assert property (p_stat_done)
    else $error("done flag not readable");
  property p_stat_empty;
    bus_i.rd && bus_i.addr == OBT_OFS_STATUS && irq_empty_o
      |=> rdata_o[OBT_FLAG_EMPTY];
  endproperty
  a_stat_empty: assert property (p_stat_empty)
    else $error("empty flag not readable");
  property p_tx_end;
    $fell(running_o) && mode_q == OBT_TX && en_q[1] |-> irq_done_o;
  endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("no done request at end of burst");
endmodule : obt_bit_timer_props

bind obt_bit_timer obt_bit_timer_props #(.CTR_W(CTR_W))
  obt_bit_timer_props_inst (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .bus_i(bus_i),
  .rdata_o(rdata_o),
  .capture_pin_i(capture_pin_i),
  .key_o(key_o),
  .irq_empty_o(irq_empty_o),
  .irq_done_o(irq_done_o),
  .running_o(running_o)
);

// *** tb/obt_far_side.sv ***
// Purpose: Far side of the timer: keyed carrier and pulse source
// Assumes: Pin changes just after a rising edge
// Notes: Counts carrier-on clocks for the bench
`timescale 1ns/100ps
module obt_far_side (
  input wire logic sys_clk_i,
  input wire logic key_i,
  input wire logic go_i,
  input wire logic [7:0] width_i,
  output logic pin_o,
  output int on_cnt_o
);
  int hold = 0;
  initial begin
    pin_o = 1'b0;
    on_cnt_o = 0;
  end
  // Carrier energy and one high pulse per request
  always @(posedge sys_clk_i) begin
    if (key_i === 1'b1) begin
      on_cnt_o <= on_cnt_o + 1;
    end
    if (go_i) begin
      pin_o <= 1'b1;
      hold <= width_i;
    end else if (hold > 1) begin
      hold <= hold - 1;
    end else begin
      pin_o <= 1'b0;
    end
  end
endmodule : obt_far_side

// *** tb/tb_ook_bit_timer.sv ***
// Purpose: Self-checking bench of the bit timer
// Assumes: Divider ratio 0 while slots are timed
// Notes: Random counts from a fixed seed
`timescale 1ns/100ps
module tb_ook_bit_timer
  import obt_pkg::*;
();
  logic sys_clk_i;
  logic rst_i = 1'b1;
  obt_bus_req_t bus_q = '0;
  logic [7:0] rdata, lo, rv, width = 8'h00;
  logic [1:0] hi, bits;
  logic cap, key, irq_e, irq_d, run, go = 1'b0;
  int on_cnt, error_cnt = 0, total_checks = 0, cyc = 0;
  int seed, exp_on, c, a;
  int q[$];
  obt_bit_timer #(.CTR_W(10)) obt_bit_timer_inst (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .bus_i(bus_q), .rdata_o(rdata), .capture_pin_i(cap),
    .key_o(key), .irq_empty_o(irq_e), .irq_done_o(irq_d), .running_o(run));
  obt_far_side obt_far_side_inst (.sys_clk_i(sys_clk_i), .key_i(key),
    .go_i(go), .width_i(width), .pin_o(cap), .on_cnt_o(on_cnt));
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    total_checks++;
    if (g !== e) begin
      $display("Error %s expected %0h seen %0h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic cy(int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cy
  task automatic wr(logic [2:0] ad, logic [7:0] d);
    @(posedge sys_clk_i);
    bus_q <= '{ad, d, 1'b1, 1'b0};
    @(posedge sys_clk_i);
    bus_q.wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [2:0] ad, logic [7:0] e, logic [7:0] m);
    @(posedge sys_clk_i);
    bus_q <= '{ad, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk_i);
    bus_q.rd <= 1'b0;
    #1 rv = rdata;
    chk("rdata", e & m, rv & m);
  endtask : rd
  // Cut a hang short
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      test_done;
    end
  end
  initial begin
    seed = 25039;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00, 8'hff);
    lo = $random(seed);
    wr(OBT_OFS_CLK_DIV, lo);
    rd(OBT_OFS_CLK_DIV, lo, 8'hff);
    wr(OBT_OFS_CLK_DIV, 8'h00);
    // Two-bit bursts, interrupts masked on even passes
    for (int it = 0; it < 3; it++) begin
      lo = $random(seed) | 8'h04;
      hi = $random(seed);
      bits = $random(seed);
      c = {hi, lo};
      q = '{bits[0], bits[1]};
      a = on_cnt;
      wr(OBT_OFS_IRQ_EN, it[0] ? 8'h05 : 8'h00);
      wr(OBT_OFS_COUNT, lo);
      wr(OBT_OFS_CTRL, {hi, 5'b01000, bits[0]});
      for (int i = 0; i < 20 && run !== 1'b1; i++) cy(1);
      wr(OBT_OFS_CTRL, {hi, 5'b01000, bits[1]});
      for (int i = 0; i < 3000 && run !== 1'b0; i++) cy(1);
      exp_on = 0;
      foreach (q[i]) exp_on += q[i] * (c + 1);
      chk("carrier", exp_on, on_cnt - a);
      rd(OBT_OFS_STATUS, 8'h05, 8'h05);
      chk("irq_done", it[0], irq_d);
      chk("irq_empty", it[0], irq_e);
      wr(OBT_OFS_STATUS, 8'h05);
      rd(OBT_OFS_STATUS, 8'h00, 8'h05);
    end
    wr(OBT_OFS_CTRL, 8'h00);
    // Two captured pulses of known widths
    wr(OBT_OFS_CTRL, 8'h20);
    for (int p = 0; p < 2; p++) begin
      width <= 8'd20 + p * 7;
      go <= 1'b1;
      cy(1);
      go <= 1'b0;
      cy(6);
      rd(OBT_OFS_CTRL, 8'h01, 8'h01);
      cy(30);
      rd(OBT_OFS_CTRL, 8'h00, 8'h01);
      rd(OBT_OFS_COUNT, width - 8'd1, 8'hff);
      if (p == 1) chk("width", 7, rv - a);
      else a = rv;
    end
    // Generic timing without keying
    wr(OBT_OFS_IRQ_EN, 8'h04);
    wr(OBT_OFS_COUNT, 8'h10);
    a = on_cnt;
    wr(OBT_OFS_CTRL, 8'h30);
    for (c = 0; c < 200 && irq_d !== 1'b1; c++) cy(1);
    chk("gen_irq", 1, irq_d);
    chk("gen_time", 1, c >= 16);
    chk("gen_key", 0, on_cnt - a);
    wr(OBT_OFS_CTRL, 8'h00);
    test_done;
  end
endmodule : tb_ook_bit_timer
